// File: ospe_defs.svh
`ifndef OSPE_DEFS_SVH
`define OSPE_DEFS_SVH
// ----------------
// timing
// ----------------
`define OSPE_CLK_KHZ      10000
`define OSPE_CYCLE_MS     1
`define OSPE_MS_CYC       (`OSPE_CYCLE_MS * `OSPE_CLK_KHZ)
`define OSPE_PRE_TRIG_MS  20
`define OSPE_PRE_FLT_MS   200
`define OSPE_MAX_TRIP_MS  1800000
`define OSPE_RESET_PCT    97
`define OSPE_LOG_DEPTH    12
`define OSPE_TRUE_RMS_MAGNITUDE_HARM    32
`define OSPE_HIST_DEPTH   256
// ----------------
// register byte offsets
// ----------------
`define OSPE_A_CTRL       6'h00
`define OSPE_A_GROUP      6'h04
`define OSPE_A_THR_IDX    6'h08
`define OSPE_A_THR_VAL    6'h0c
`define OSPE_A_TRIP_DLY   6'h10
`define OSPE_A_RST_DLY    6'h14
`define OSPE_A_IDMT_K     6'h18
`define OSPE_A_STATUS     6'h1c
`define OSPE_A_CNT_START  6'h20
`define OSPE_A_CNT_TRIP   6'h24
`define OSPE_A_CNT_BLOCK  6'h28
`define OSPE_A_CNT_CLR    6'h2c
`define OSPE_A_LOG_SEL    6'h30
`define OSPE_A_LOG_TS_LO  6'h34
`define OSPE_A_LOG_TS_HI  6'h38
`define OSPE_A_LOG_INFO   6'h3c
// ----------------
// control fields and reset values
// ----------------
`define OSPE_F_INSEL      1:0
`define OSPE_F_MAGTYPE    3:2
`define OSPE_F_SIDE       4
`define OSPE_F_REMOTE     5
`define OSPE_F_LNMODE     8:6
`define OSPE_F_FORCE      10:9
`define OSPE_F_FILTER     12:11
`define OSPE_F_IDMT       13
`define OSPE_CTRL_RST     32'h0000_0000
`define OSPE_THR_RST      16'h04b0
`define OSPE_TRIP_DLY_RST 21'h00_0064
`define OSPE_RST_DLY_RST  21'h00_0014
`define OSPE_IDMT_K_RST   16'h0064
`endif

// File: ospe_meas_model.sv
`timescale 1ns/1ns
`default_nettype none
module ospe_meas_model (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire logic [15:0]    lvl,
  output ospe_pkg::ospe_side_t meas_side1,
  output ospe_pkg::ospe_side_t meas_side2,
  output logic [47:0]         time_ms
);
  logic [3:0] tick_r;
  // level on side 1 phase a; full-scale side 2 exposes a wrong side pick
  always_comb begin
    meas_side1 = '0;
    meas_side1.ph[0].rms = lvl;
    meas_side2 = '1;
  end
  // millisecond clock of ten cycles, matching MS_CYC of the bench
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_r  <= 4'h0;
      time_ms <= '0;
    end else if (tick_r == 4'h9) begin
      tick_r  <= 4'h0;
      time_ms <= time_ms + 48'h1;
    end else begin
      tick_r <= tick_r + 4'h1;
    end
  end
endmodule : ospe_meas_model
`default_nettype wire

// File: ospe_pkg.sv
package ospe_pkg;
  typedef enum logic [1:0] {
    OSPE_NORMAL, OSPE_START, OSPE_TRIP, OSPE_BLOCKED
  } ospe_state_t;
  typedef struct packed {
    logic [15:0] rms;
    logic [15:0] true_rms_magnitude;
    logic [15:0] pp;
  } ospe_mag_t;
  typedef struct packed {
    ospe_mag_t [2:0]          ph;
    logic signed [2:0][15:0]  re;
    logic signed [2:0][15:0]  im;
    ospe_mag_t                coarse;
    ospe_mag_t                sens;
  } ospe_side_t;
  typedef struct packed {
    logic        valid;
    logic        test;
    logic [8:0]  on;
    logic [8:0]  off;
    logic [47:0] stamp;
  } ospe_event_t;
  typedef struct packed {
    logic [47:0] stamp;
    logic [1:0]  code;
    logic [3:0]  ftype;
    logic [15:0] fault;
    logic [15:0] pre20;
    logic [15:0] pre200;
    logic [20:0] remain;
    logic [2:0]  group;
  } ospe_log_t;
endpackage : ospe_pkg

// File: ospe_stage.sv
// Overview of operation
// RULE_01 - on/off events for stage and phases
// RULE_02 - filter selects on, off or both
// RULE_03 - every event carries its time stamp
// RULE_04 - clearable start, trip, block counters
// RULE_05 - own twelve-entry time-stamped log
// RULE_06 - log only on-transitions with process data
// RULE_07 - log stamp, event, fault, -20 ms current
// RULE_08 - log -200 ms pre-fault current
// RULE_09 - log remaining trip time, setting group
// RULE_10 - select coarse, sensitive or calculated residual
// RULE_11 - calculated residual is fundamental zero sequence
// RULE_12 - magnitude type only for measured channels
// RULE_13 - true rms covers 32 harmonics
// RULE_14 - side selection, side 1 default
// RULE_15 - one threshold, pickup on any phase
// RULE_16 - release below 97 percent of threshold
// RULE_17 - remote threshold write when allowed only
// RULE_18 - logical node mode, gated by global enable
// RULE_19 - forced status when forcing enabled
// RULE_20 - general settings ignore setting group
// RULE_21 - group switch updates threshold live
// RULE_22 - definite and inverse trip delay
// RULE_23 - block at pickup gives blocked, else start
// RULE_24 - full log overwrites the oldest entry
`include "ospe_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ospe_stage #(
  parameter int MS_CYC = `OSPE_MS_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire ospe_pkg::ospe_side_t meas_side1,
  input  wire ospe_pkg::ospe_side_t meas_side2,
  input  wire logic [47:0]         time_ms,
  input  wire logic                block_in,
  input  wire logic                ln_mode_en,
  input  wire logic                force_en,
  input  wire logic                remote_thr_wr,
  input  wire logic [15:0]         remote_thr,
  output logic                     start_o,
  output logic                     trip_o,
  output logic                     blocked_o,
  output logic [2:0]               phase_start_o,
  output logic [2:0]               phase_trip_o,
  output logic                     test_o,
  output ospe_pkg::ospe_event_t    event_o
);
  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] be_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [15:0] max16(input logic [15:0] a,
      input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : max16

  function automatic logic [15:0] pick_mag(input ospe_pkg::ospe_mag_t m,
      input logic [1:0] t);
    if (t == 2'h1) begin
      return m.true_rms_magnitude; // RULE_13
    end else if (t == 2'h2) begin
      return m.pp;
    end else begin
      return m.rms;
    end
  endfunction : pick_mag

  function automatic logic [16:0] absv(input logic signed [17:0] v);
    logic [17:0] a;
    a = v[17] ? 18'(-v) : 18'(v);
    return a[16:0];
  endfunction : absv

  function automatic logic [3:0] log_idx(input logic [3:0] wp,
      input logic [3:0] k);
    logic [4:0] s;
    s = 5'(wp) + 5'(`OSPE_LOG_DEPTH) - 5'd1 - 5'(k);
    return (s >= 5'(`OSPE_LOG_DEPTH)) ? 4'(s - 5'(`OSPE_LOG_DEPTH)) : s[3:0];
  endfunction : log_idx

  // ----------------
  // bus slave: one wait state, then answer
  // ----------------
  logic        ack_r;
  logic        req;
  logic        wr_go;
  logic        rd_cap;
  assign req = avs_read | avs_write;
  // gating with ce keeps the master from finishing while state is frozen
  assign avs_waitrequest = req & ~(ack_r & ce);
  assign wr_go  = avs_write & ack_r & ce;
  assign rd_cap = avs_read & ~ack_r & ce;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------
  // settings
  // ----------------
  logic [31:0]      ctrl_r;
  logic [2:0]       grp_r;
  logic [2:0]       thr_idx_r;
  logic [15:0]      thr_r [8];
  logic [20:0]      trip_dly_r;
  logic [20:0]      rst_dly_r;
  logic [15:0]      idmt_k_r;
  logic [3:0]       log_sel_r;
  logic [31:0]      wv;
  assign wv = be_merge(32'h0, avs_writedata, avs_byteenable);

  // general settings live outside the group array on purpose
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r     <= `OSPE_CTRL_RST; // RULE_20
      grp_r      <= 3'h0;
      thr_idx_r  <= 3'h0;
      trip_dly_r <= `OSPE_TRIP_DLY_RST;
      rst_dly_r  <= `OSPE_RST_DLY_RST;
      idmt_k_r   <= `OSPE_IDMT_K_RST;
      log_sel_r  <= 4'h0;
    end else if (ce && wr_go) begin
      if (avs_address == `OSPE_A_CTRL) begin
        ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable);
      end else if (avs_address == `OSPE_A_GROUP) begin
        grp_r <= wv[2:0]; // RULE_21
      end else if (avs_address == `OSPE_A_THR_IDX) begin
        thr_idx_r <= wv[2:0];
      end else if (avs_address == `OSPE_A_TRIP_DLY) begin
        trip_dly_r <= wv[20:0];
      end else if (avs_address == `OSPE_A_RST_DLY) begin
        rst_dly_r <= wv[20:0];
      end else if (avs_address == `OSPE_A_IDMT_K) begin
        idmt_k_r <= wv[15:0];
      end else if (avs_address == `OSPE_A_LOG_SEL) begin
        log_sel_r <= (wv[3:0] < 4'(`OSPE_LOG_DEPTH)) ? wv[3:0] : 4'h0;
      end
    end
  end

  // per-group thresholds; remote writes only reach the active group
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < 8; g++) begin
        thr_r[g] <= `OSPE_THR_RST;
      end
    end else if (ce) begin
      if (remote_thr_wr && ctrl_r[`OSPE_F_REMOTE]) begin
        thr_r[grp_r] <= remote_thr; // RULE_17
      end else if (wr_go && avs_address == `OSPE_A_THR_VAL) begin
        thr_r[thr_idx_r] <= wv[15:0];
      end
    end
  end

  // ----------------
  // measurement selection
  // ----------------
  ospe_pkg::ospe_side_t ms;
  logic [1:0]           mtype;
  logic signed [17:0]   sre;
  logic signed [17:0]   sim;
  logic [16:0]          are;
  logic [16:0]          aim;
  logic [16:0]          calc_mag;
  logic [15:0]          mag [4];
  logic [15:0]          thr;
  logic [15:0]          mag_max;
  assign ms    = ctrl_r[`OSPE_F_SIDE] ? meas_side2 : meas_side1; // RULE_14
  assign mtype = ctrl_r[`OSPE_F_MAGTYPE];
  assign thr   = thr_r[grp_r]; // RULE_15 RULE_21
  // zero sequence from fundamental phasors, magnitude by max + min/2
  // an element select loses the sign, so it is restored before widening
  assign sre = 18'(signed'(ms.re[0])) + 18'(signed'(ms.re[1]))
             + 18'(signed'(ms.re[2])); // RULE_11
  assign sim = 18'(signed'(ms.im[0])) + 18'(signed'(ms.im[1]))
             + 18'(signed'(ms.im[2]));
  assign are = absv(sre);
  assign aim = absv(sim);
  assign calc_mag = (are > aim) ? 17'((are + (aim >> 1)) / 3)
                                : 17'((aim + (are >> 1)) / 3);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      mag[p] = pick_mag(ms.ph[p], mtype);
    end
    if (ctrl_r[`OSPE_F_INSEL] == 2'h1) begin
      mag[3] = pick_mag(ms.sens, mtype); // RULE_10 RULE_12
    end else if (ctrl_r[`OSPE_F_INSEL] == 2'h2) begin
      mag[3] = calc_mag[16] ? 16'hffff : calc_mag[15:0]; // RULE_12
    end else begin
      mag[3] = pick_mag(ms.coarse, mtype); // RULE_10
    end
  end
  assign mag_max = max16(max16(mag[0], mag[1]), max16(mag[2], mag[3]));

  // ----------------
  // node mode
  // ----------------
  logic [2:0] mode;
  logic       st_off;
  logic       blk;
  // 0 on, 1 blocked, 2 test, 3 test/blocked, 4 off
  assign mode   = ln_mode_en ? ctrl_r[`OSPE_F_LNMODE] : 3'h0; // RULE_18
  assign st_off = (mode == 3'h4);
  assign blk    = block_in | (mode == 3'h1) | (mode == 3'h3);
  assign test_o = (mode == 3'h2) | (mode == 3'h3);

  // ----------------
  // pickup with reset hysteresis
  // ----------------
  logic [3:0] pick_r;
  logic       pick;
  assign pick = |pick_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pick_r <= 4'h0;
    end else if (ce) begin
      for (int c = 0; c < 4; c++) begin
        if (st_off) begin
          pick_r[c] <= 1'b0;
        end else if (mag[c] > thr) begin
          pick_r[c] <= 1'b1; // RULE_15
        end else if (32'(mag[c]) * 32'd100 <
                     32'(thr) * 32'(`OSPE_RESET_PCT)) begin
          pick_r[c] <= 1'b0; // RULE_16
        end
      end
    end
  end

  // ----------------
  // program cycle tick and current history
  // ----------------
  logic [13:0] tick_cnt_r;
  logic        tick;
  logic [15:0] hist [`OSPE_HIST_DEPTH];
  logic [7:0]  hp_r;
  assign tick = (tick_cnt_r == 14'(MS_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 14'h0;
    end else if (ce) begin
      tick_cnt_r <= tick ? 14'h0 : tick_cnt_r + 14'h1;
    end
  end

  // one sample per program cycle; 256 deep covers the 200 ms look-back
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hp_r <= 8'h0;
    end else if (ce && tick) begin
      hp_r <= hp_r + 8'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && tick) begin
      hist[hp_r] <= mag_max;
    end
  end

  // ----------------
  // delay timing and state machine
  // ----------------
  ospe_pkg::ospe_state_t st_r;
  logic [20:0] elap_r;
  logic [20:0] rel_r;
  logic [31:0] idmt_ms;
  logic [20:0] delay;
  logic [20:0] remain;
  logic [15:0] over;
  assign over    = (mag_max > thr) ? mag_max - thr : 16'h1;
  // inverse curve k * set / (I - set), clipped to the longest delay
  assign idmt_ms = (32'(idmt_k_r) * 32'(thr)) / 32'(over);
  assign delay   = !ctrl_r[`OSPE_F_IDMT] ? trip_dly_r :
                   (idmt_ms > 32'(`OSPE_MAX_TRIP_MS)) ?
                   21'(`OSPE_MAX_TRIP_MS) : idmt_ms[20:0]; // RULE_22
  assign remain  = (delay > elap_r) ? delay - elap_r : 21'h0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r   <= ospe_pkg::OSPE_NORMAL;
      elap_r <= 21'h0;
      rel_r  <= 21'h0;
    end else if (ce) begin
      if (st_off) begin
        st_r   <= ospe_pkg::OSPE_NORMAL;
        elap_r <= 21'h0;
        rel_r  <= 21'h0;
      end else begin
        case (st_r)
          ospe_pkg::OSPE_NORMAL: begin
            elap_r <= 21'h0;
            rel_r  <= 21'h0;
            if (pick) begin
              st_r <= blk ? ospe_pkg::OSPE_BLOCKED
                          : ospe_pkg::OSPE_START; // RULE_23
            end
          end
          ospe_pkg::OSPE_START: begin
            if (blk) begin
              st_r <= ospe_pkg::OSPE_BLOCKED; // RULE_23
            end else if (!pick) begin
              // release delay; a returning pickup resumes the timer
              if (tick) begin
                rel_r <= rel_r + 21'h1;
              end
              if (rel_r >= rst_dly_r) begin
                st_r <= ospe_pkg::OSPE_NORMAL;
              end
            end else begin
              rel_r <= 21'h0;
              if (tick) begin
                elap_r <= elap_r + 21'h1;
              end
              if (remain == 21'h0) begin
                st_r <= ospe_pkg::OSPE_TRIP; // RULE_22
              end
            end
          end
          ospe_pkg::OSPE_TRIP: begin
            if (pick) begin
              rel_r <= 21'h0;
            end else begin
              if (tick) begin
                rel_r <= rel_r + 21'h1;
              end
              if (rel_r >= rst_dly_r) begin
                st_r <= ospe_pkg::OSPE_NORMAL;
              end
            end
          end
          ospe_pkg::OSPE_BLOCKED: begin
            elap_r <= 21'h0;
            rel_r  <= 21'h0;
            if (!pick) begin
              st_r <= ospe_pkg::OSPE_NORMAL;
            end else if (!blk) begin
              st_r <= ospe_pkg::OSPE_START;
            end
          end
          default: st_r <= ospe_pkg::OSPE_NORMAL;
        endcase
      end
    end
  end

  // ----------------
  // outputs, forcing and events
  // ----------------
  ospe_pkg::ospe_state_t cond;
  logic [8:0] sv;
  logic [8:0] sv_r;
  logic [8:0] on_v;
  logic [8:0] off_v;
  logic [1:0] filt;
  always_comb begin
    if (force_en && ctrl_r[`OSPE_F_FORCE] != 2'h0) begin
      cond = ospe_pkg::ospe_state_t'(ctrl_r[`OSPE_F_FORCE]); // RULE_19
    end else begin
      cond = st_r;
    end
  end
  assign start_o   = (cond == ospe_pkg::OSPE_START) |
                     (cond == ospe_pkg::OSPE_TRIP);
  assign trip_o    = (cond == ospe_pkg::OSPE_TRIP);
  assign blocked_o = (cond == ospe_pkg::OSPE_BLOCKED);
  assign phase_start_o = start_o ? pick_r[2:0] : 3'h0;
  assign phase_trip_o  = trip_o ? pick_r[2:0] : 3'h0;
  assign sv    = {phase_trip_o, phase_start_o, blocked_o, trip_o, start_o};
  assign on_v  = sv & ~sv_r; // RULE_01
  assign off_v = ~sv & sv_r; // RULE_01
  assign filt  = ctrl_r[`OSPE_F_FILTER];

  // the filter decides what reaches the event buffer, not what is counted
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sv_r    <= 9'h0;
      event_o <= '0;
    end else if (ce) begin
      sv_r          <= sv;
      event_o.on    <= (filt == 2'h2) ? 9'h0 : on_v; // RULE_02
      event_o.off   <= (filt == 2'h1) ? 9'h0 : off_v; // RULE_02
      event_o.valid <= ((filt == 2'h2) ? 1'b0 : |on_v) |
                       ((filt == 2'h1) ? 1'b0 : |off_v);
      event_o.test  <= test_o;
      event_o.stamp <= time_ms; // RULE_03
    end
  end

  // ----------------
  // cumulative counters
  // ----------------
  logic [31:0] cnt_r [3];
  logic        cnt_clr;
  assign cnt_clr = wr_go && (avs_address == `OSPE_A_CNT_CLR);

  // an occurrence in the clear cycle survives as a count of one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= 32'h0;
      end
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (cnt_clr) begin
          cnt_r[i] <= {31'h0, on_v[i]}; // RULE_04
        end else if (on_v[i]) begin
          cnt_r[i] <= cnt_r[i] + 32'h1; // RULE_04
        end
      end
    end
  end

  // ----------------
  // operation log
  // ----------------
  ospe_pkg::ospe_log_t log_m [`OSPE_LOG_DEPTH];
  ospe_pkg::ospe_log_t le;
  logic [3:0] lwp_r;
  logic [3:0] lcnt_r;
  logic       log_go;
  logic [1:0] lcode;
  assign log_go = |on_v[2:0]; // RULE_06
  assign lcode  = on_v[1] ? 2'h1 : on_v[0] ? 2'h0 : 2'h2;
  always_comb begin
    le.stamp  = time_ms; // RULE_07
    le.code   = lcode;
    le.ftype  = pick_r;
    le.fault  = mag_max;
    le.pre20  = hist[hp_r - 8'(`OSPE_PRE_TRIG_MS)]; // RULE_07
    le.pre200 = hist[hp_r - 8'(`OSPE_PRE_FLT_MS)]; // RULE_08
    le.remain = remain; // RULE_09
    le.group  = grp_r; // RULE_09
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lwp_r  <= 4'h0;
      lcnt_r <= 4'h0;
    end else if (ce && log_go) begin
      lwp_r <= (lwp_r == 4'(`OSPE_LOG_DEPTH - 1)) ? 4'h0
                                                 : lwp_r + 4'h1; // RULE_24
      if (lcnt_r != 4'(`OSPE_LOG_DEPTH)) begin
        lcnt_r <= lcnt_r + 4'h1; // RULE_05
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && log_go) begin
      log_m[lwp_r] <= le; // RULE_05
    end
  end

  // ----------------
  // read path
  // ----------------
  ospe_pkg::ospe_log_t lr;
  logic [31:0] rd;
  assign lr = log_m[log_idx(lwp_r, log_sel_r)];
  always_comb begin
    rd = 32'h0;
    if (avs_address == `OSPE_A_CTRL) begin
      rd = ctrl_r;
    end else if (avs_address == `OSPE_A_GROUP) begin
      rd = {29'h0, grp_r};
    end else if (avs_address == `OSPE_A_THR_IDX) begin
      rd = {29'h0, thr_idx_r};
    end else if (avs_address == `OSPE_A_THR_VAL) begin
      rd = {16'h0, thr_r[thr_idx_r]};
    end else if (avs_address == `OSPE_A_TRIP_DLY) begin
      rd = {11'h0, trip_dly_r};
    end else if (avs_address == `OSPE_A_RST_DLY) begin
      rd = {11'h0, rst_dly_r};
    end else if (avs_address == `OSPE_A_IDMT_K) begin
      rd = {16'h0, idmt_k_r};
    end else if (avs_address == `OSPE_A_STATUS) begin
      rd = {1'b0, remain, lcnt_r, pick_r, cond};
    end else if (avs_address == `OSPE_A_CNT_START) begin
      rd = cnt_r[0];
    end else if (avs_address == `OSPE_A_CNT_TRIP) begin
      rd = cnt_r[1];
    end else if (avs_address == `OSPE_A_CNT_BLOCK) begin
      rd = cnt_r[2];
    end else if (avs_address == `OSPE_A_LOG_SEL) begin
      rd = {28'h0, log_sel_r};
    end else if (avs_address == `OSPE_A_LOG_TS_LO) begin
      rd = lr.stamp[31:0];
    end else if (avs_address == `OSPE_A_LOG_TS_HI) begin
      rd = {lr.group, lr.ftype, lr.code, 7'h0, lr.stamp[47:32]};
    end else if (avs_address == `OSPE_A_LOG_INFO) begin
      rd = {lr.fault, lr.pre20};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (rd_cap) begin
      avs_readdata <= rd;
    end
  end
endmodule : ospe_stage
`default_nettype wire

// File: ospe_stage_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ospe_stage_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  ce,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  input wire logic [47:0]           time_ms,
  input wire logic                  start_o,
  input wire logic                  trip_o,
  input wire logic                  blocked_o,
  input wire logic [2:0]            phase_trip_o,
  input wire ospe_pkg::ospe_event_t event_o
);
  // ----------------
  // bus and status event checks
  // ----------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // a request that the slave has not answered yet
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  // the event one cycle after a status edge
  sequence s_on(int i);
    ##1 (event_o.valid && event_o.on[i]);
  endsequence
  sequence s_off(int i);
    ##1 (event_o.valid && event_o.off[i]);
  endsequence
  a_bus_one_wait: assert property (s_req |=> !avs_waitrequest)
    else $error("bus answer late");
  a_start_on: assert property ($rose(start_o) |-> s_on(0))
    else $error("start on event missing");
  a_trip_on: assert property ($rose(trip_o) |-> s_on(1))
    else $error("trip on event missing");
  a_block_on: assert property ($rose(blocked_o) |-> s_on(2))
    else $error("block on event missing");
  a_start_off: assert property ($fell(start_o) |-> s_off(0))
    else $error("start off event missing");
  a_ev_nonempty: assert property (event_o.valid |-> (event_o.on | event_o.off) != 9'h000)
    else $error("empty event");
  // stamp is the time seen at the edge that registered the event
  a_ev_stamp: assert property (event_o.valid |-> event_o.stamp == $past(time_ms))
    else $error("event stamp wrong");
  a_blk_nostart: assert property (blocked_o |-> !start_o)
    else $error("start while blocked");
  a_ph_trip: assert property (|phase_trip_o |-> trip_o)
    else $error("phase trip without trip");
endmodule : ospe_stage_chk
`default_nettype wire

// File: ospe_stage_tb.sv
`include "ospe_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ospe_stage_tb;
  logic                  ref_clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic [5:0]            avs_address = 6'h00;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [31:0]           got;
  logic [15:0]           lvl = 16'h0;
  logic                  block_in = 1'b0;
  logic                  remote_thr_wr = 1'b0;
  ospe_pkg::ospe_side_t  meas_side1;
  ospe_pkg::ospe_side_t  meas_side2;
  logic [47:0]           time_ms;
  logic                  start_o;
  logic                  trip_o;
  logic                  blocked_o;
  logic                  test_o;
  logic [2:0]            phase_start_o;
  logic [2:0]            phase_trip_o;
  ospe_pkg::ospe_event_t event_o;
  int                    num_errors = 0;
  int                    checked = 0;
  int                    cyc = 0;
  // ----------------
  // clock, design and measurement side
  // ----------------
  always #50 ref_clk = ~ref_clk;
  ospe_stage #(.MS_CYC(10)) u_dut (.ref_clk, .rst_b, .ce(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .meas_side1, .meas_side2, .time_ms, .block_in, .ln_mode_en(1'b0), .force_en(1'b0),
    .remote_thr_wr, .remote_thr(lvl), .start_o, .trip_o, .blocked_o, .phase_start_o,
    .phase_trip_o, .test_o, .event_o);
  ospe_meas_model u_meas (.ref_clk, .rst_b, .lvl, .meas_side1, .meas_side2, .time_ms);
  // ----------------
  // tasks
  // ----------------
  task automatic end_of_test();
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // request held until the answer edge; data taken in the answer cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    got = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic cmpw(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: word %h expected %h", $time, g, e);
    end
  endtask : cmpw
  task automatic cmpb(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : cmpb
  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmpw(got & m, e);
  endtask : rdc
  // new level and block, then n cycles, then a settled sample point
  task automatic step(input logic [15:0] l, input logic b, input int n);
    @(posedge ref_clk);
    lvl      <= l;
    block_in <= b;
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : step
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(`OSPE_A_CTRL, 32'hffffffff, 32'h0);
    rdc(`OSPE_A_THR_VAL, 32'h0000ffff, 32'h04b0);
    bus(1'b1, `OSPE_A_THR_VAL, 32'h0064);
    @(posedge ref_clk);
    remote_thr_wr <= 1'b1;
    @(posedge ref_clk);
    remote_thr_wr <= 1'b0;
    rdc(`OSPE_A_THR_VAL, 32'h0000ffff, 32'h0064);
    step(16'h0000, 1'b0, 250); // history covers the 20 ms look-back before the first log
    // 97 is the release boundary: held, 96 releases
    step(16'h0065, 1'b0, 20);
    cmpb(phase_start_o[0], 1'b1);
    step(16'h0061, 1'b0, 400);
    cmpb(start_o, 1'b1);
    cmpb(trip_o, 1'b0);
    step(16'h0061, 1'b0, 800);
    cmpb(trip_o, 1'b1);
    step(16'h0060, 1'b0, 400);
    cmpb(start_o, 1'b0);
    rdc(`OSPE_A_CNT_START, 32'hffffffff, 32'h1);
    rdc(`OSPE_A_CNT_TRIP, 32'hffffffff, 32'h1);
    bus(1'b1, `OSPE_A_LOG_SEL, 32'h0);
    rdc(`OSPE_A_LOG_TS_HI, 32'he1800000, 32'h00800000);
    rdc(`OSPE_A_LOG_INFO, 32'hffffffff, 32'h00610061);
    bus(1'b1, `OSPE_A_LOG_SEL, 32'h1);
    rdc(`OSPE_A_LOG_TS_HI, 32'he1800000, 32'h0);
    rdc(`OSPE_A_LOG_INFO, 32'hffffffff, 32'h00650000);
    step(16'h0065, 1'b1, 20);
    cmpb(blocked_o, 1'b1);
    cmpb(start_o, 1'b0);
    step(16'h0000, 1'b0, 300);
    rdc(`OSPE_A_CNT_BLOCK, 32'hffffffff, 32'h1);
    bus(1'b1, `OSPE_A_CNT_CLR, 32'h1);
    rdc(`OSPE_A_CNT_START, 32'hffffffff, 32'h0);
    rdc(`OSPE_A_CNT_CLR, 32'hffffffff, 32'h0);
    end_of_test();
  end
  // hang guard, about three and a half times the sequence
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      end_of_test();
    end
  end
endmodule : ospe_stage_tb
bind ospe_stage ospe_stage_chk u_chk (.ref_clk, .rst_b, .ce, .avs_read, .avs_write,
  .avs_waitrequest, .time_ms, .start_o, .trip_o, .blocked_o, .phase_trip_o, .event_o);
`default_nettype wire
